// ### can_acceptance_filter_config.sv
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`include "can_filter_consts.svh"

module can_acceptance_filter_config (
   // Clock, reset and clock enable.
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   ce,
   // APB slave.
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [11:0]            paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   // Received frame identifier.
   input  wire logic                   rx_valid,
   input  wire can_filter_pkg::rx_frame_t rx_frame,
   // Acceptance result.
   output logic                        match_valid,
   output can_filter_pkg::match_t      match
);
   import can_filter_pkg::*;

   filter_ctl_t  ctl_w [32];
   logic [31:0]  pat_w [32];
   logic [31:0]  mask_ff [4];
   logic [31:0]  hit_w;
   logic [31:0]  rd_word;
   logic         addr_ok;
   logic         ctl_hit;
   logic         pat_hit;
   logic         mask_hit;
   logic         wr_fire;
   logic [2:0]   ctl_idx;
   logic [4:0]   pat_idx;
   logic [1:0]   mask_idx;
   logic [31:0]  rx_word;
   match_t       nxt_match;
   logic         pready_ff;
   logic         pslverr_ff;
   logic [31:0]  prdata_ff;
   logic         match_valid_ff;
   match_t       match_ff;
   match_t       last_ff;

   assign ctl_idx  = paddr[4:2];
   assign pat_idx  = paddr[6:2];
   assign mask_idx = paddr[3:2];
   assign ctl_hit  = (paddr[11:5] == `CTL_SEL) && (paddr[1:0] == 2'h0);
   assign pat_hit  = (paddr[11:7] == `PAT_SEL) && (paddr[1:0] == 2'h0);
   assign mask_hit = (paddr[11:4] == `MASK_SEL) && (paddr[1:0] == 2'h0);

   // A write lands only at the access edge where pready is seen high.
   assign wr_fire = ce && psel && penable && pready_ff && pwrite;

   // Received identifier laid out like a pattern word for a bitwise compare.
   assign rx_word = {rx_frame.sid, 1'b0, rx_frame.ext, 1'b0, rx_frame.eid};

   // Read mux and address decode; unmapped addresses answer with an error.
   always_comb begin
      rd_word = 32'h0000_0000;
      addr_ok = 1'b1;
      if (ctl_hit) begin
         rd_word = {ctl_w[{ctl_idx, 2'h3}], ctl_w[{ctl_idx, 2'h2}],
                    ctl_w[{ctl_idx, 2'h1}], ctl_w[{ctl_idx, 2'h0}]};
      end else if (paddr == `STAT_ADDR) begin
         rd_word[`STAT_HIT_BIT]          = last_ff.hit;
         rd_word[`STAT_FLT_LO +: 5]      = last_ff.filter;
         rd_word[`STAT_FIFO_LO +: 5]     = last_ff.fifo;
      end else if (mask_hit) begin
         rd_word = mask_ff[mask_idx];
      end else if (pat_hit) begin
         rd_word = pat_w[pat_idx];
      end else begin
         addr_ok = 1'b0;
      end
   end

   // The slave answers in the first access cycle: pready is set at setup.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else if (ce) begin
         pready_ff  <= psel && !penable;
         pslverr_ff <= psel && !penable && !addr_ok;
      end
   end

   // Read data is captured at setup so it comes from a flip-flop.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
      end else if (ce && psel && !penable) begin
         prdata_ff <= pwrite ? 32'h0000_0000 : rd_word;
      end
   end

   // Acceptance masks; the frame type bit is always compared, so it
   // has no mask bit.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int m = 0; m < 4; m++) begin
            mask_ff[m] <= `MASK_RST;
         end
      end else if (wr_fire && mask_hit) begin
         mask_ff[mask_idx] <= pwdata & `MASK_IMPL;
      end
   end

   // Per-filter storage and comparison.
   for (genvar i = 0; i < 32; i++) begin : g_filter
      filter_ctl_t ctl_ff;
      logic [31:0] pat_ff;
      logic [31:0] cmp_mask;
      logic [7:0]  wbyte;

      assign wbyte = pwdata[8*(i%4) +: 8];

      // Enable is always writable so software can take a filter out;
      // the selects only follow while the filter is still disabled.
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            ctl_ff <= `CTL_RST;
         end else if (wr_fire && ctl_hit && ctl_idx == 3'(i / 4)) begin
            ctl_ff.en <= wbyte[`EN_BIT];
            if (!ctl_ff.en) begin
               ctl_ff.msel <= wbyte[`MSEL_HI:`MSEL_LO];
               ctl_ff.fsel <= wbyte[`FSEL_HI:`FSEL_LO];
            end
         end
      end

      // Pattern writes are dropped while the filter is live, so a frame
      // is never judged against a half-updated pattern.
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            pat_ff <= `PAT_RST;
         end else if (wr_fire && pat_hit && pat_idx == 5'(i) &&
                      !ctl_ff.en) begin
            pat_ff <= pwdata & `PAT_IMPL;
         end
      end

      // Standard frames carry no extended bits, so those are not compared.
      assign cmp_mask = mask_ff[ctl_ff.msel] &
                        (rx_frame.ext ? `MASK_IMPL : `SID_FIELDS);
      assign hit_w[i] = ctl_ff.en &&
                        (pat_ff[`FRAME_TYPE_SELECT_BIT] == rx_frame.ext) &&
                        (((rx_word ^ pat_ff) & cmp_mask) == 32'h0);
      assign ctl_w[i] = ctl_ff;
      assign pat_w[i] = pat_ff;
   end

   // Lowest-numbered matching filter wins when several accept a frame.
   always_comb begin
      nxt_match = '0;
      for (int f = 31; f >= 0; f--) begin
         if (hit_w[f]) begin
            nxt_match.hit    = 1'b1;
            nxt_match.filter = 5'(f);
            nxt_match.fifo   = ctl_w[f].fsel;
         end
      end
   end

   // Result is presented one cycle after the frame and also kept for reads.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_valid_ff <= 1'b0;
         match_ff       <= '0;
         last_ff        <= '0;
      end else if (ce) begin
         match_valid_ff <= rx_valid;
         if (rx_valid) begin
            match_ff <= nxt_match;
            last_ff  <= nxt_match;
         end
      end
   end

   assign prdata      = prdata_ff;
   assign pready      = pready_ff;
   assign pslverr     = pslverr_ff;
   assign match_valid = match_valid_ff;
   assign match       = match_ff;

   // Checks on the register file and the acceptance path.
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_en_write;
      wr_fire && ctl_hit |=>
         ctl_w[{$past(ctl_idx), 2'h0}].en == $past(pwdata[7]);
   endproperty
   a_en_write: assert property (p_en_write)
      else $error("Filter enable did not follow the write.");

   property p_msel_write;
      wr_fire && ctl_hit && !ctl_w[{ctl_idx, 2'h1}].en |=>
         ctl_w[{$past(ctl_idx), 2'h1}].msel == $past(pwdata[14:13]);
   endproperty
   a_msel_write: assert property (p_msel_write)
      else $error("Mask select of upper filter not written.");

   property p_fifo_route;
      match_valid && match.hit |-> match.fifo == ctl_w[match.filter].fsel;
   endproperty
   a_fifo_route: assert property (p_fifo_route)
      else $error("Matched frame routed to the wrong FIFO.");

   property p_ctl_layout;
      psel && penable && pready && !pwrite && $past(ctl_hit) |->
         prdata[15] == ctl_w[{$past(ctl_idx), 2'h1}].en;
   endproperty
   a_ctl_layout: assert property (p_ctl_layout)
      else $error("Upper filter enable not read in bit 15.");

   property p_ctl_locked;
      wr_fire && ctl_hit && ctl_w[{ctl_idx, 2'h0}].en |=>
         ctl_w[{$past(ctl_idx), 2'h0}].fsel ==
         $past(ctl_w[{ctl_idx, 2'h0}].fsel);
   endproperty
   a_ctl_locked: assert property (p_ctl_locked)
      else $error("FIFO select changed on an enabled filter.");

   property p_sid_write;
      wr_fire && pat_hit && !ctl_w[pat_idx].en |=>
         pat_w[$past(pat_idx)][31:19] == $past({pwdata[31:21], 1'b0,
                                                 pwdata[19]});
   endproperty
   a_sid_write: assert property (p_sid_write)
      else $error("Pattern identifier or frame type not stored.");

   property p_unimpl_zero;
      psel && penable && pready && !pwrite && $past(pat_hit) |->
         prdata[20] == 1'b0 && prdata[18] == 1'b0;
   endproperty
   a_unimpl_zero: assert property (p_unimpl_zero)
      else $error("Unimplemented pattern bit read as one.");

   property p_pat_locked;
      wr_fire && pat_hit && ctl_w[pat_idx].en |=>
         pat_w[$past(pat_idx)] == $past(pat_w[pat_idx]);
   endproperty
   a_pat_locked: assert property (p_pat_locked)
      else $error("Pattern changed while its filter was enabled.");

   property p_no_filter;
      ce && rx_valid && hit_w == 32'h0 |=> match_valid && !match.hit;
   endproperty
   a_no_filter: assert property (p_no_filter)
      else $error("Frame accepted with no matching filter.");

   property p_apb_answer;
      ce && psel && !penable |=> pready;
   endproperty
   a_apb_answer: assert property (p_apb_answer)
      else $error("Slave did not answer in the first access cycle.");

   property p_fsel_lower;
      wr_fire && ctl_hit && !ctl_w[{ctl_idx, 2'h0}].en |=>
         ctl_w[{$past(ctl_idx), 2'h0}].fsel == $past(pwdata[4:0]);
   endproperty
   a_fsel_lower: assert property (p_fsel_lower)
      else $error("FIFO select of lower filter not written.");

   property p_fsel_upper;
      wr_fire && ctl_hit && !ctl_w[{ctl_idx, 2'h1}].en |=>
         ctl_w[{$past(ctl_idx), 2'h1}].fsel == $past(pwdata[12:8]);
   endproperty
   a_fsel_upper: assert property (p_fsel_upper)
      else $error("Upper FIFO select not taken from bits 12 to 8.");

   property p_msel_locked;
      wr_fire && ctl_hit && ctl_w[{ctl_idx, 2'h1}].en |=>
         ctl_w[{$past(ctl_idx), 2'h1}].msel ==
         $past(ctl_w[{ctl_idx, 2'h1}].msel);
   endproperty
   a_msel_locked: assert property (p_msel_locked)
      else $error("Mask select changed on an enabled filter.");

   property p_eid_write;
      wr_fire && pat_hit && !ctl_w[pat_idx].en |=>
         pat_w[$past(pat_idx)][17:0] == $past(pwdata[17:0]);
   endproperty
   a_eid_write: assert property (p_eid_write)
      else $error("Extended identifier pattern not stored.");

   property p_off_ignored;
      ce && rx_valid && !ctl_w[0].en |=>
         !(match.hit && match.filter == 5'h00);
   endproperty
   a_off_ignored: assert property (p_off_ignored)
      else $error("Disabled filter accepted a frame.");

   property p_type_match;
      ce && rx_valid && nxt_match.hit |->
         pat_w[nxt_match.filter][`FRAME_TYPE_SELECT_BIT] == rx_frame.ext;
   endproperty
   a_type_match: assert property (p_type_match)
      else $error("Frame accepted by a filter of the other frame type.");

   property p_mask_write;
      wr_fire && mask_hit |=>
         mask_ff[$past(mask_idx)] == ($past(pwdata) & `MASK_IMPL);
   endproperty
   a_mask_write: assert property (p_mask_write)
      else $error("Acceptance mask not stored.");

   property p_lowest_wins;
      ce && rx_valid && hit_w[0] |=> match.hit && match.filter == 5'h00;
   endproperty
   a_lowest_wins: assert property (p_lowest_wins)
      else $error("Filter zero matched but another filter won.");

   property p_match_hold;
      !(ce && rx_valid) |=> $stable(match);
   endproperty
   a_match_hold: assert property (p_match_hold)
      else $error("Match result changed without a frame.");

   property p_ce_freeze;
      !ce |=> $stable(match_valid) && $stable(pready) && $stable(prdata);
   endproperty
   a_ce_freeze: assert property (p_ce_freeze)
      else $error("Outputs moved while the clock enable was low.");

   property p_err_data;
      pready && pslverr |-> prdata == 32'h0000_0000;
   endproperty
   a_err_data: assert property (p_err_data)
      else $error("Refused transfer returned nonzero read data.");

   c_hit:       cover property (match_valid && match.hit);
   c_locked:    cover property (wr_fire && pat_hit && ctl_w[pat_idx].en);
   c_slverr:    cover property (pready && pslverr);
   c_miss:      cover property (match_valid && !match.hit);
   c_ce_low:    cover property (!ce && rx_valid);

endmodule

// ### can_filter_consts.svh
// How it works
// - One enable bit per filter; one joins acceptance, zero leaves it out.
// - Two-bit mask select per filter picks acceptance mask 0 to 3.
// - Five-bit FIFO select per filter names the receive FIFO, 0 to 31.
// - Halfword holds two filters: upper in bits 15..8, lower in bits 7..0.
// - Mask and FIFO selects change only while the filter is disabled.
// - Pattern bits 31..21 hold the standard identifier that must match.
// - Pattern bit 19 picks extended or standard frames; resets to zero.
// - Pattern bits 17..0 hold extended identifier; bits 20 and 18 read zero.
// - Pattern writes are ignored while the filter is enabled.
`ifndef CAN_FILTER_CONSTS_SVH
`define CAN_FILTER_CONSTS_SVH

// Address decode: region select fields of paddr.
`define CTL_SEL      7'h00
`define STAT_ADDR    12'h020
`define MASK_SEL     8'h04
`define PAT_SEL      5'h01

// Control byte fields, one byte per filter.
`define EN_BIT       7
`define MSEL_HI      6
`define MSEL_LO      5
`define FSEL_HI      4
`define FSEL_LO      0

// Pattern and mask word fields.
`define SID_HI       31
`define SID_LO       21
`define FRAME_TYPE_SELECT_BIT     19
`define EID_HI       17
`define EID_LO       0
`define PAT_IMPL     32'hFFEB_FFFF
`define MASK_IMPL    32'hFFE3_FFFF
`define SID_FIELDS   32'hFFE0_0000

// Status word fields.
`define STAT_HIT_BIT 16
`define STAT_FLT_LO  8
`define STAT_FIFO_LO 0

// Reset values.
`define CTL_RST      8'h00
`define PAT_RST      32'h0000_0000
`define MASK_RST     32'h0000_0000

`endif

// ### can_filter_pkg.sv
package can_filter_pkg;

   // One filter's control byte, packed in register bit order.
   typedef struct packed {
      logic       en;
      logic [1:0] msel;
      logic [4:0] fsel;
   } filter_ctl_t;

   // Identifier of a received frame.
   typedef struct packed {
      logic        ext;
      logic [10:0] sid;
      logic [17:0] eid;
   } rx_frame_t;

   // Acceptance result for one frame.
   typedef struct packed {
      logic       hit;
      logic [4:0] filter;
      logic [4:0] fifo;
   } match_t;

endpackage

// ### can_frame_source.sv
`timescale 1ns/1ps
module can_frame_source (
   // Clock.
   input  wire logic                      pclk,
   // Frame identifier towards the block.
   output logic                           rx_valid,
   output can_filter_pkg::rx_frame_t      rx_frame
);
   import can_filter_pkg::*;

   // Nothing is offered before the first call.
   initial begin
      rx_valid = 1'b0;
      rx_frame = '0;
   end

   // One frame per call, valid for a single cycle. Afterwards the lines
   // show the inverse, so a late sample cannot match by luck.
   task automatic send(input rx_frame_t fr);
      rx_valid <= 1'b1;
      rx_frame <= fr;
      @(posedge pclk);
      rx_valid <= 1'b0;
      rx_frame <= ~fr;
   endtask
endmodule

// ### can_acceptance_filter_config_bench.sv
`timescale 1ns/1ps
`include "can_filter_consts.svh"
module can_acceptance_filter_config_bench;
   import can_filter_pkg::*;
   logic        pclk, presetn, ce, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, rx_valid, match_valid;
   rx_frame_t   rx_frame;
   match_t      match;
   match_t      lst;
   logic [7:0]  ctl [32];
   logic [31:0] pat [32];
   logic [31:0] msk [4];
   int          n_errors, samples_checked, cyc;

   can_acceptance_filter_config can_acceptance_filter_config_i (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_valid(rx_valid), .rx_frame(rx_frame),
      .match_valid(match_valid), .match(match));
   can_frame_source can_frame_source_i (
      .pclk(pclk), .rx_valid(rx_valid), .rx_frame(rx_frame));

   // Free-running clock at 200 MHz.
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         n_errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic end_sim;
      $display("errors=%0d checks=%0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // A hang ends the run as a failure.
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         end_sim;
      end
   end

   // Expected read value and error flag; status shows the last result.
   function automatic logic [31:0] rdm(input logic [11:0] a, output logic e);
      e = 1'b0;
      if (a == 12'h020)
         return {15'h0, lst.hit, 3'h0, lst.filter, 3'h0, lst.fifo};
      if (a[1:0] == 2'h0 && a < 12'h020)
         return {ctl[{a[4:2], 2'h3}], ctl[{a[4:2], 2'h2}],
                 ctl[{a[4:2], 2'h1}], ctl[{a[4:2], 2'h0}]};
      if (a[1:0] == 2'h0 && a >= 12'h040 && a < 12'h050)
         return msk[a[3:2]];
      if (a[1:0] == 2'h0 && a >= 12'h080 && a < 12'h100)
         return pat[a[6:2]];
      e = 1'b1;
      return 32'h0;
   endfunction

   // Locked filters keep selects and pattern; enable stays writable.
   function automatic void wrm(input logic [11:0] a, input logic [31:0] d);
      if (a < 12'h020) begin
         for (int k = 0; k < 4; k++) begin
            if (ctl[{a[4:2], k[1:0]}][7])
               ctl[{a[4:2], k[1:0]}][7] = d[8*k+7];
            else
               ctl[{a[4:2], k[1:0]}] = d[8*k+:8];
         end
      end else if (a >= 12'h040 && a < 12'h080)
         msk[a[3:2]] = d & `MASK_IMPL;
      else if (a >= 12'h080 && !ctl[a[6:2]][7])
         pat[a[6:2]] = d & `PAT_IMPL;
   endfunction

   // Lowest enabled filter whose masked bits and frame type agree.
   function automatic match_t em(input rx_frame_t fr);
      logic [31:0] w, c;
      w = {fr.sid, 1'b0, fr.ext, 1'b0, fr.eid};
      for (int f = 0; f < 32; f++) begin
         c = msk[ctl[f][6:5]] & (fr.ext ? `MASK_IMPL : `SID_FIELDS);
         if (ctl[f][7] && pat[f][19] == fr.ext && ((w ^ pat[f]) & c) == 0)
            return {1'b1, f[4:0], ctl[f][4:0]};
      end
      return '0;
   endfunction

   // APB transfer; the answer is taken at the edge where pready is high.
   task automatic acc(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      logic [31:0] ex;
      logic        er;
      ex = rdm(a, er);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only pready going high or the bench timeout ends this wait.
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      chk(pslverr, er);
      if (!w)
         chk(prdata, ex);
      else if (!er)
         wrm(a, d);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Reads every word up to the pattern end, status included.
   task automatic sweep;
      for (int a = 0; a < 256; a += 4)
         acc(1'b0, a[11:0], 32'h0);
      acc(1'b0, 12'h082, 32'h0);
   endtask

   initial begin
      rx_frame_t fr;
      match_t    ex;
      int        k;
      n_errors = 0;
      lst = '0;
      samples_checked = 0;
      cyc = 0;
      presetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      for (int i = 0; i < 32; i++) begin
         ctl[i] = 8'h00;
         pat[i] = 32'h0;
         msk[i[1:0]] = 32'h0;
      end
      void'($urandom(31));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      sweep;
      // Rounds of control then pattern writes, some hitting enabled filters.
      repeat (3) begin
         for (int g = 0; g < 8; g++)
            acc(1'b1, 12'(4 * g), $urandom);
         for (int a = 64; a < 256; a += 4)
            acc(1'b1, a[11:0], $urandom);
         acc(1'b1, 12'h024, $urandom);
         acc(1'b1, 12'h020, $urandom);
         sweep;
      end
      // Frames near stored patterns, with a bit flipped now and then.
      repeat (300) begin
         k = $urandom % 32;
         fr.ext = 1'($urandom % 2);
         fr.sid = pat[k][31:21] ^ 11'(($urandom % 2) << ($urandom % 11));
         fr.eid = pat[k][17:0];
         ex = em(fr);
         lst = ex;
         can_frame_source_i.send(fr);
         @(negedge pclk);
         chk(match_valid, 1'b1);
         chk(match.hit, ex.hit);
         chk(match, ex);
         @(negedge pclk);
         chk(match_valid, 1'b0);
         @(posedge pclk);
      end
      // A frame offered while the clock enable is low must be ignored.
      ce <= 1'b0;
      can_frame_source_i.send(fr);
      @(negedge pclk);
      chk(match_valid, 1'b0);
      chk(match, lst);
      @(posedge pclk);
      ce <= 1'b1;
      sweep;
      end_sim;
   end
endmodule
